// ==== timer_flags_defs.svh ====
// Register offsets, field positions and reset values for the timer flag block
`ifndef TIMER_FLAGS_DEFS_SVH
`define TIMER_FLAGS_DEFS_SVH

// Printed offsets are not all multiples of four: kept as indexes
`define IDX_CHANNEL_EVENT_FLAGS   8'h0E
`define IDX_OVERFLOW_EVENT_FLAGS  8'h0F
`define IDX_CHANNEL_FIRST         8'h10
`define IDX_CHANNEL_LAST          8'h1F
// Own choices
`define IDX_FREE_RUNNING_COUNTER  8'h04
`define IDX_CONTROL               8'h06
`define IDX_PRECISION_PRESCALE    8'h2B
`define IDX_IRQ_STATUS            8'h30
`define IDX_IRQ_MASK              8'h31
`define IDX_HIGHEST               8'h3F

// Control register fields
`define CTL_TIMER_ENABLE          0
`define CTL_PULSE_ACC_ENABLE      1
`define CTL_FAST_FLAG_CLEAR       2
`define CTL_PRECISION_SELECT      3
`define CTL_WIDTH                 4

`define RESET_BYTE                8'h00
`define RESET_CTL                 4'h0
`define RESET_WORD                32'h0000_0000

`define RESP_OKAY                 2'b00
`define RESP_SLVERR               2'b10

// Interrupt status bits: any channel flag, overflow flag
`define IRQ_CHANNEL               0
`define IRQ_OVERFLOW              1
`define IRQ_WIDTH                 2

`endif

// ==== timer_flags_pkg.sv ====
// Types shared by the timer flag block
package timer_flags_pkg;
  typedef enum logic [1:0] {
    wr_idle_state = 2'b00,
    wr_resp_state = 2'b01
  } write_state_type;
  typedef enum logic [1:0] {
    rd_idle_state = 2'b00,
    rd_data_state = 2'b01
  } read_state_type;
endpackage

// ==== flag_bit_cell.sv ====
// One sticky flag bit with set, write-one clear and fast clear
`timescale 1ns/10ps
`include "timer_flags_defs.svh"
module flag_bit_cell (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Events
  input  wire logic set_event,
  input  wire logic clear_event,
  // State
  output logic      flag
);
  logic next_flag;

  // Set wins over a clear in the same cycle
  always_comb begin
    next_flag = flag;
    if (clear_event) begin
      next_flag = 1'b0;
    end
    if (set_event) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule // flag_bit_cell

// ==== precision_prescaler.sv ====
// Eight-bit precision prescaler with deferred factor load
`timescale 1ns/10ps
`include "timer_flags_defs.svh"
module precision_prescaler (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic       precision_timer_select_bit,
  input  wire logic [7:0] precision_divide_value,
  // Output
  output logic            prescaled_tick,
  output logic [7:0]      active_divide
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] next_active;
  logic       next_tick;
  logic [7:0] wanted;

  always_comb begin
    // Without precision mode the factor is zero: a tick every cycle
    wanted = precision_timer_select_bit ? precision_divide_value
                                        : `RESET_BYTE;
    next_count  = count;
    next_active = active_divide;
    next_tick   = 1'b0;
    if (run) begin
      if (count == active_divide) begin
        next_count = `RESET_BYTE;
        next_tick  = 1'b1;
      end else begin
        next_count = count + 8'h01;
      end
    end else begin
      next_count = `RESET_BYTE;
    end
    // New factor only taken when the counter returns to zero
    if (next_count == `RESET_BYTE) begin
      next_active = wanted;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count          <= `RESET_BYTE;
      active_divide  <= `RESET_BYTE;
      prescaled_tick <= 1'b0;
    end else begin
      count          <= next_count;
      active_divide  <= next_active;
      prescaled_tick <= next_tick;
    end
  end
endmodule // precision_prescaler

// ==== timer_flags_prescaler.sv ====
// Timer flag registers, precision prescaler and AXI4-Lite slave
`timescale 1ns/10ps
`include "timer_flags_defs.svh"

module timer_flags_prescaler
  import timer_flags_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Timer events
  input  wire logic [7:0]  channel_event,
  input  wire logic        counter_overflow_event,
  // Prescaler output
  output logic             prescaled_tick,
  // Interrupt
  output logic             irq,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  write_state_type          wr_state;
  write_state_type          next_wr_state;
  read_state_type           rd_state;
  read_state_type           next_rd_state;
  logic [31:0]              aw_hold;
  logic [31:0]              next_aw_hold;
  logic                     aw_have;
  logic                     next_aw_have;
  logic [31:0]              w_hold;
  logic [31:0]              next_w_hold;
  logic [3:0]               ws_hold;
  logic [3:0]               next_ws_hold;
  logic                     w_have;
  logic                     next_w_have;
  logic [1:0]               next_bresp;
  logic [31:0]              next_rdata;
  logic [1:0]               next_rresp;

  logic [`CTL_WIDTH-1:0]    control;
  logic [`CTL_WIDTH-1:0]    next_control;
  logic [7:0]               precision_prescale_select;
  logic [7:0]               next_prescale_select;
  logic [`IRQ_WIDTH-1:0]    irq_mask;
  logic [`IRQ_WIDTH-1:0]    next_irq_mask;
  logic [`IRQ_WIDTH-1:0]    irq_status;
  logic [`IRQ_WIDTH-1:0]    next_irq_status;

  logic [7:0]               channel_event_flags;
  logic [7:0]               overflow_event_flags;
  logic [7:0]               chan_clear;
  logic [7:0]               ovf_clear;
  logic [7:0]               ovf_set;
  logic [7:0]               active_divide;

  logic                     wr_fire;
  logic                     rd_fire;
  logic [7:0]               wr_idx;
  logic [7:0]               rd_idx;
  logic                     clear_allowed;
  logic                     fast_clear;
  logic                     wr_ok;
  logic                     rd_ok;

  assign s_axi_awready = (wr_state == wr_idle_state) && !aw_have;
  assign s_axi_wready  = (wr_state == wr_idle_state) && !w_have;
  assign s_axi_arready = (rd_state == rd_idle_state);
  assign s_axi_bvalid  = (wr_state == wr_resp_state);
  assign s_axi_rvalid  = (rd_state == rd_data_state);

  // Write commits once both halves are held
  assign wr_fire = (wr_state == wr_idle_state) && aw_have && w_have;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_idx  = aw_hold[9:2];
  assign rd_idx  = s_axi_araddr[9:2];
  assign wr_ok   = (aw_hold[31:10] == 22'h000000) && ws_hold[0];
  assign rd_ok   = (s_axi_araddr[31:10] == 22'h000000)
                   && (rd_idx <= `IDX_HIGHEST);

  assign clear_allowed = control[`CTL_TIMER_ENABLE]
                         || control[`CTL_PULSE_ACC_ENABLE];
  assign fast_clear    = control[`CTL_FAST_FLAG_CLEAR];

  // Write-one clear, and fast clear by channel register access
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : g_channel
      logic [7:0] chan_idx;
      assign chan_idx = `IDX_CHANNEL_FIRST + 8'(ch * 2);
      assign chan_clear[ch] =
          (wr_fire && wr_ok && wr_idx == `IDX_CHANNEL_EVENT_FLAGS
           && w_hold[ch] && clear_allowed)
          || (fast_clear && rd_fire && rd_ok
              && rd_idx == chan_idx)
          || (fast_clear && wr_fire && wr_ok
              && wr_idx == chan_idx);
      flag_bit_cell u_chan_flag (
        .clk         (clk),
        .rst         (rst),
        .set_event   (channel_event[ch]),
        .clear_event (chan_clear[ch]),
        .flag        (channel_event_flags[ch])
      );
    end
  endgenerate

  // Only bit 7 of the overflow register is implemented
  assign ovf_set   = {counter_overflow_event, 7'h00};
  assign ovf_clear = ({8{wr_fire && wr_ok && clear_allowed
                        && wr_idx == `IDX_OVERFLOW_EVENT_FLAGS}}
                      & w_hold[7:0])
                   | {8{fast_clear
                        && ((wr_fire && wr_ok
                             && wr_idx == `IDX_FREE_RUNNING_COUNTER)
                            || (rd_fire && rd_ok
                             && rd_idx == `IDX_FREE_RUNNING_COUNTER))}};
  genvar ob;
  generate
    for (ob = 0; ob < 8; ob = ob + 1) begin : g_overflow
      flag_bit_cell u_ovf_flag (
        .clk         (clk),
        .rst         (rst),
        .set_event   (ovf_set[ob]),
        .clear_event (ovf_clear[ob]),
        .flag        (overflow_event_flags[ob])
      );
    end
  endgenerate

  precision_prescaler u_prescaler (
    .clk                        (clk),
    .rst                        (rst),
    .run                        (control[`CTL_TIMER_ENABLE]),
    .precision_timer_select_bit (control[`CTL_PRECISION_SELECT]),
    .precision_divide_value     (precision_prescale_select),
    .prescaled_tick             (prescaled_tick),
    .active_divide              (active_divide)
  );

  always_comb begin
    next_wr_state        = wr_state;
    next_aw_hold         = aw_hold;
    next_aw_have         = aw_have;
    next_w_hold          = w_hold;
    next_ws_hold         = ws_hold;
    next_w_have          = w_have;
    next_bresp           = s_axi_bresp;
    next_control         = control;
    next_prescale_select = precision_prescale_select;
    next_irq_mask        = irq_mask;
    case (wr_state)
      wr_idle_state: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_aw_hold = s_axi_awaddr;
          next_aw_have = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_w_hold  = s_axi_wdata;
          next_ws_hold = s_axi_wstrb;
          next_w_have  = 1'b1;
        end
        if (wr_fire) begin
          next_aw_have  = 1'b0;
          next_w_have   = 1'b0;
          next_wr_state = wr_resp_state;
          next_bresp    = wr_ok && wr_idx <= `IDX_HIGHEST
                          ? `RESP_OKAY : `RESP_SLVERR;
          if (wr_ok && wr_idx == `IDX_CONTROL) begin
            next_control = w_hold[`CTL_WIDTH-1:0];
          end else if (wr_ok && wr_idx == `IDX_PRECISION_PRESCALE) begin
            next_prescale_select = w_hold[7:0];
          end else if (wr_ok && wr_idx == `IDX_IRQ_MASK) begin
            next_irq_mask = w_hold[`IRQ_WIDTH-1:0];
          end
        end
      end
      wr_resp_state: begin
        if (s_axi_bready) begin
          next_wr_state = wr_idle_state;
        end
      end
      default: next_wr_state = wr_idle_state;
    endcase
  end

  always_comb begin
    next_rd_state   = rd_state;
    next_rdata      = s_axi_rdata;
    next_rresp      = s_axi_rresp;
    next_irq_status = irq_status;
    // Reading the status clears it; a new event still wins
    if (rd_fire && rd_ok && rd_idx == `IDX_IRQ_STATUS) begin
      next_irq_status = '0;
    end
    if (|channel_event) begin
      next_irq_status[`IRQ_CHANNEL] = 1'b1;
    end
    if (counter_overflow_event) begin
      next_irq_status[`IRQ_OVERFLOW] = 1'b1;
    end
    case (rd_state)
      rd_idle_state: begin
        if (rd_fire) begin
          next_rd_state = rd_data_state;
          next_rresp    = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
          next_rdata    = `RESET_WORD;
          if (!rd_ok) begin
            next_rdata = `RESET_WORD;
          end else if (rd_idx == `IDX_CHANNEL_EVENT_FLAGS) begin
            next_rdata[7:0] = channel_event_flags;
          end else if (rd_idx == `IDX_OVERFLOW_EVENT_FLAGS) begin
            next_rdata[7:0] = overflow_event_flags;
          end else if (rd_idx == `IDX_CONTROL) begin
            next_rdata[`CTL_WIDTH-1:0] = control;
          end else if (rd_idx == `IDX_PRECISION_PRESCALE) begin
            next_rdata[7:0]  = precision_prescale_select;
            next_rdata[15:8] = active_divide;
          end else if (rd_idx == `IDX_IRQ_STATUS) begin
            next_rdata[`IRQ_WIDTH-1:0] = irq_status;
          end else if (rd_idx == `IDX_IRQ_MASK) begin
            next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
          end
        end
      end
      rd_data_state: begin
        if (s_axi_rready) begin
          next_rd_state = rd_idle_state;
        end
      end
      default: next_rd_state = rd_idle_state;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_state                  <= wr_idle_state;
      rd_state                  <= rd_idle_state;
      aw_hold                   <= `RESET_WORD;
      aw_have                   <= 1'b0;
      w_hold                    <= `RESET_WORD;
      ws_hold                   <= 4'h0;
      w_have                    <= 1'b0;
      s_axi_bresp               <= `RESP_OKAY;
      s_axi_rdata               <= `RESET_WORD;
      s_axi_rresp               <= `RESP_OKAY;
      control                   <= `RESET_CTL;
      precision_prescale_select <= `RESET_BYTE;
      irq_mask                  <= '0;
      irq_status                <= '0;
      irq                       <= 1'b0;
    end else begin
      wr_state                  <= next_wr_state;
      rd_state                  <= next_rd_state;
      aw_hold                   <= next_aw_hold;
      aw_have                   <= next_aw_have;
      w_hold                    <= next_w_hold;
      ws_hold                   <= next_ws_hold;
      w_have                    <= next_w_have;
      s_axi_bresp               <= next_bresp;
      s_axi_rdata               <= next_rdata;
      s_axi_rresp               <= next_rresp;
      control                   <= next_control;
      precision_prescale_select <= next_prescale_select;
      irq_mask                  <= next_irq_mask;
      irq_status                <= next_irq_status;
      irq                       <= |(next_irq_status & next_irq_mask);
    end
  end
endmodule // timer_flags_prescaler

// ==== timer_flags_checker.sv ====
// Bus and readback checks on the timer flag block ports
`timescale 1ns/10ps
`include "timer_flags_defs.svh"
module timer_flags_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Timer side
  input wire logic [7:0]  channel_event,
  input wire logic        counter_overflow_event,
  input wire logic        prescaled_tick,
  input wire logic        irq,
  // Write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Address of the read in flight, to judge its data
  logic [31:0] ra;
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("arready while rvalid");
  property p_wans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wans: assert property (p_wans) else $error("write not answered");
  property p_awblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_awblk: assert property (p_awblk) else $error("ready while bvalid");
  property p_cef;
    s_axi_rvalid && ra[9:2] == `IDX_CHANNEL_EVENT_FLAGS
      |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_cef: assert property (p_cef) else $error("flag high bits set");
  property p_oef;
    s_axi_rvalid && ra[9:2] == `IDX_OVERFLOW_EVENT_FLAGS
      |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:0] == 7'h0;
  endproperty
  a_oef: assert property (p_oef) else $error("overflow loose bits set");
  property p_err;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[31:10] != 22'h0 ||
      s_axi_araddr[9:2] > `IDX_HIGHEST)
      |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped read accepted");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_tick: cover property (prescaled_tick);
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule // timer_flags_checker

bind timer_flags_prescaler timer_flags_checker i_chk (.*);

// ==== timer_flags_prescaler_bench.sv ====
// Self-checking bench for the timer flag block
`timescale 1ns/10ps
`include "timer_flags_defs.svh"
module timer_flags_prescaler_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  channel_event = 8'h00;
  logic        counter_overflow_event = 1'b0;
  logic        prescaled_tick, irq;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs;
  int          mismatches = 0, checked = 0, cyc = 0, a, b;
  logic [7:0]  pv [3] = '{8'h00, 8'h03, 8'hFF};

  timer_flags_prescaler i_dut (.*);

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task ck(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Readies are sampled mid-cycle, where they are settled
  task wr(input logic [7:0] ix, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {22'h0, ix, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw | w) begin
      @(negedge clk);
      aw = aw & !s_axi_awready;
      w = w & !s_axi_wready;
      @(posedge clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    bs = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    // Let an edge pass so a following call never re-raises bready at once
    @(posedge clk);
  endtask

  task rd(input logic [7:0] ix, output logic [31:0] d);
    s_axi_araddr <= {22'h0, ix, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task rc(input logic [7:0] ix, input logic [31:0] e);
    rd(ix, v);
    ck(v, e);
  endtask

  task ev(input logic [7:0] c, input logic o);
    channel_event <= c;
    counter_overflow_event <= o;
    @(posedge clk);
    channel_event <= 8'h00;
    counter_overflow_event <= 1'b0;
  endtask

  task ci(input logic e);
    @(negedge clk);
    ck(32'(irq), 32'(e));
    @(posedge clk);
  endtask

  task tk(output int t);
    do @(negedge clk); while (prescaled_tick !== 1'b1);
    t = cyc;
    @(posedge clk);
  endtask

  task t_reset;
    rc(`IDX_CHANNEL_EVENT_FLAGS, 32'h0);
    rc(`IDX_OVERFLOW_EVENT_FLAGS, 32'h0);
    rc(`IDX_CONTROL, 32'h0);
    rc(`IDX_IRQ_MASK, 32'h0);
    rc(8'h40, 32'h0);
    ck(32'(rs), 32'(`RESP_SLVERR));
    // Low byte strobe missing: refused, control untouched
    s_axi_wstrb <= 4'hE;
    wr(`IDX_CONTROL, 32'hF);
    s_axi_wstrb <= 4'hF;
    ck(32'(bs), 32'(`RESP_SLVERR));
    rc(`IDX_CONTROL, 32'h0);
    wr(8'h40, 32'h0);
    ck(32'(bs), 32'(`RESP_SLVERR));
    wr(`IDX_IRQ_MASK, 32'h0);
    ck(32'(bs), 32'(`RESP_OKAY));
  endtask

  task t_flags;
    ev(8'hA5, 1'b1);
    rc(`IDX_CHANNEL_EVENT_FLAGS, 32'hA5);
    wr(`IDX_CHANNEL_EVENT_FLAGS, 32'hFF);
    wr(`IDX_OVERFLOW_EVENT_FLAGS, 32'hFF);
    rc(`IDX_CHANNEL_EVENT_FLAGS, 32'hA5);
    rc(`IDX_OVERFLOW_EVENT_FLAGS, 32'h80);
    wr(`IDX_CONTROL, 32'h1);
    wr(`IDX_CHANNEL_EVENT_FLAGS, 32'hFFFF_FF05);
    rc(`IDX_CHANNEL_EVENT_FLAGS, 32'hA0);
    wr(`IDX_CONTROL, 32'h2);
    wr(`IDX_CHANNEL_EVENT_FLAGS, 32'h80);
    rc(`IDX_CHANNEL_EVENT_FLAGS, 32'h20);
    wr(`IDX_OVERFLOW_EVENT_FLAGS, 32'h80);
    rc(`IDX_OVERFLOW_EVENT_FLAGS, 32'h0);
  endtask

  // Fast clear works with both enables off
  task t_fast;
    wr(`IDX_CONTROL, 32'h4);
    ev(8'hFF, 1'b1);
    rc(`IDX_CHANNEL_FIRST, 32'h0);
    wr(8'h12, 32'h0);
    rc(`IDX_CHANNEL_EVENT_FLAGS, 32'hFC);
    rc(`IDX_FREE_RUNNING_COUNTER, 32'h0);
    rc(`IDX_OVERFLOW_EVENT_FLAGS, 32'h0);
    ev(8'h00, 1'b1);
    wr(`IDX_FREE_RUNNING_COUNTER, 32'h0);
    rc(`IDX_OVERFLOW_EVENT_FLAGS, 32'h0);
    wr(`IDX_CONTROL, 32'h0);
    ev(8'h00, 1'b1);
    wr(`IDX_FREE_RUNNING_COUNTER, 32'h0);
    rc(`IDX_OVERFLOW_EVENT_FLAGS, 32'h80);
  endtask

  task t_irq;
    rd(`IDX_IRQ_STATUS, v);
    ev(8'h01, 1'b0);
    repeat (2) @(posedge clk);
    ci(1'b0);
    wr(`IDX_IRQ_MASK, 32'h3);
    ci(1'b1);
    rc(`IDX_IRQ_STATUS, 32'h1);
    ci(1'b0);
    rc(`IDX_IRQ_STATUS, 32'h0);
  endtask

  // First tick after a write may still use the old factor
  task t_presc;
    wr(`IDX_CONTROL, 32'h9);
    for (int i = 0; i < 3; i++) begin
      wr(`IDX_PRECISION_PRESCALE, 32'(pv[i]));
      tk(a);
      tk(a);
      tk(b);
      ck(32'(b - a), 32'(pv[i]) + 32'h1);
    end
    rc(`IDX_PRECISION_PRESCALE, 32'h0000_FFFF);
    tk(a);
    wr(`IDX_PRECISION_PRESCALE, 32'h1);
    tk(b);
    ck(32'(b - a), 32'h100);
    tk(a);
    ck(32'(a - b), 32'h2);
    wr(`IDX_CONTROL, 32'h1);
    tk(a);
    tk(a);
    tk(b);
    ck(32'(b - a), 32'h1);
  endtask

  task test_done;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_flags;
    t_fast;
    t_irq;
    t_presc;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule // timer_flags_prescaler_bench
